// File: rlts_cfg.svh
`ifndef RLTS_CFG_SVH
`define RLTS_CFG_SVH
// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define RLTS_ADDR_TX_DELAY 8'h06
`define RLTS_ADDR_NO_REPLY 8'h07
`define RLTS_ADDR_RX_BLANK 8'h08
`define RLTS_ADDR_RX_FILT 8'h09
`define RLTS_ADDR_RX_GAIN 8'h0A
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RLTS_RST_TX_DELAY 8'h00
`define RLTS_RST_NO_REPLY 8'h07
`define RLTS_RST_RX_BLANK 8'h07
`define RLTS_RST_RX_FILT 8'h41
`define RLTS_RST_RX_GAIN 8'h01
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RLTS_FILT_SEL_LSB 0
`define RLTS_FILT_LF_OPEN 2
`define RLTS_FILT_SETTLE 3
`define RLTS_GAIN_ATT_BIT 0
`define RLTS_GAIN_LOWSUP_BIT 1
`define RLTS_GAIN_MIX_BIT 2
`define RLTS_GAIN_HYST_LSB 3
`define RLTS_GAIN_STEP_LSB 5
// ----------------------------------------------------------------
// Timing: steps in ns, clock period in ns
// ----------------------------------------------------------------
`define RLTS_CLK_PERIOD_NS 40
`define RLTS_FINE_STEP_NS 6400
`define RLTS_COARSE_STEP_NS 25600
`define RLTS_FINE_STEP_CYC (`RLTS_FINE_STEP_NS / `RLTS_CLK_PERIOD_NS)
`define RLTS_COARSE_PER_FINE (`RLTS_COARSE_STEP_NS / `RLTS_FINE_STEP_NS)
`define RLTS_LF_PERIODS_MIN 6
`endif

// File: rlts_pkg.sv
`default_nettype none
package rlts_pkg;
  typedef struct packed {
    logic [2:0] gain_step;
    logic [1:0] hyst_step;
    logic single_ended;
    logic low_supply;
    logic attenuate;
  } rlts_gain_t;
  typedef struct packed {
    logic settle_fast;
    logic lf_open;
    logic [1:0] rx_filter_select;
  } rlts_filt_t;
  typedef enum logic [1:0] {
    RLTS_IDLE = 2'b00,
    RLTS_RUN = 2'b01
  } rlts_cnt_state_t;
endpackage : rlts_pkg
`default_nettype wire

// File: rlts_tag_model.sv
`default_nettype none
module rlts_tag_model
(
  // Clock and air events
  input wire logic i_clock,
  input wire logic i_tx_end,
  input wire logic i_reply,
  // Demodulated reply
  output logic o_lf_edge,
  output logic o_rx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = -1;
  initial o_lf_edge = 1'b0;
  initial o_rx_data = 1'b0;
  // The idle line toggles so no stale level can pass for data.
  always @(posedge i_clock)
  begin
    o_rx_data <= ~o_rx_data;
    o_lf_edge <= 1'b0;
    if (i_tx_end && i_reply)
      cnt <= 0;
    else if (cnt >= 0 && cnt < 30)
    begin
      cnt <= cnt + 1;
      o_lf_edge <= cnt >= 8 && cnt[0];
    end
  end
endmodule // rlts_tag_model
`default_nettype wire

// File: rlts_timing_rx_setup.sv
// Behaviour
// - Auto transmit waits programmed delay after reception.
// - Zero delay disables delayed auto transmission.
// - No-reply timeout starts when transmission ends.
// - No-reply steps 25.6us, eight bit value.
// - Timeout interrupt unless 6-10 link periods seen.
// - Receiver input ignored during blanking after transmit.
// - Blanking steps 6.4us, eight bit value.
// - Zero blanking enables receiver right after transmit.
// - Reset clears transmit delay value.
// - Reset presets no-reply value to 07.
// - Reset presets filter setup to 41.
// - Two-bit field selects receive filter band.
// - Settling bit doubles first-stage coupling speed.
// - Filter bit opens low-frequency side for FM0.
// - Upper gain field lowers gain 3dB steps.
// - Lower gain field raises hysteresis 5dB steps.
// - Mixer bit selects differential or single-ended input.
// - Timeout expiry sets interrupt status bit zero.
`default_nettype none
`include "rlts_cfg.svh"
module rlts_timing_rx_setup
  import rlts_pkg::*;
#(
  parameter int STEP_CYCLES = `RLTS_FINE_STEP_CYC,
  parameter int LF_PERIODS_MIN = `RLTS_LF_PERIODS_MIN
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_chip_enable,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_write,
  output logic [7:0] o_reg_rdata,
  // Frame events
  input wire logic i_tx_end,
  input wire logic i_rx_end,
  input wire logic i_auto_tx_pending,
  input wire logic i_lf_edge,
  input wire logic i_rx_data,
  input wire logic i_irq_status_clear,
  // Timing results
  output logic o_auto_tx_start,
  output logic o_rx_enable,
  output logic o_rx_data_gated,
  output logic o_no_reply_irq,
  output logic [7:0] o_irq_status,
  // Receiver configuration
  output rlts_filt_t o_filter_cfg,
  output rlts_gain_t o_gain_cfg
);
  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Chip disable acts like power-on reset on the register file.
  logic [7:0] tx_delay_wait_q;
  logic [7:0] no_reply_timeout_q;
  logic [7:0] receive_blanking_time_q;
  logic [7:0] receiver_filter_setup_q;
  logic [7:0] receiver_gain_mixer_setup_q;

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_delay_wait_q <= `RLTS_RST_TX_DELAY;
      no_reply_timeout_q <= `RLTS_RST_NO_REPLY;
      receive_blanking_time_q <= `RLTS_RST_RX_BLANK;
      receiver_filter_setup_q <= `RLTS_RST_RX_FILT;
      receiver_gain_mixer_setup_q <= `RLTS_RST_RX_GAIN;
    end
    else if (!i_chip_enable)
    begin
      tx_delay_wait_q <= `RLTS_RST_TX_DELAY;
      no_reply_timeout_q <= `RLTS_RST_NO_REPLY;
      receive_blanking_time_q <= `RLTS_RST_RX_BLANK;
      receiver_filter_setup_q <= `RLTS_RST_RX_FILT;
      receiver_gain_mixer_setup_q <= `RLTS_RST_RX_GAIN;
    end
    else if (i_reg_write)
    begin
      case (i_reg_addr)
        `RLTS_ADDR_TX_DELAY: tx_delay_wait_q <= i_reg_wdata;
        `RLTS_ADDR_NO_REPLY: no_reply_timeout_q <= i_reg_wdata;
        `RLTS_ADDR_RX_BLANK: receive_blanking_time_q <= i_reg_wdata;
        `RLTS_ADDR_RX_FILT: receiver_filter_setup_q <= i_reg_wdata;
        `RLTS_ADDR_RX_GAIN: receiver_gain_mixer_setup_q <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data is registered; unmapped addresses read zero.
  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_reg_rdata <= 8'h00;
    end
    else
    begin
      case (i_reg_addr)
        `RLTS_ADDR_TX_DELAY: o_reg_rdata <= tx_delay_wait_q;
        `RLTS_ADDR_NO_REPLY: o_reg_rdata <= no_reply_timeout_q;
        `RLTS_ADDR_RX_BLANK: o_reg_rdata <= receive_blanking_time_q;
        `RLTS_ADDR_RX_FILT: o_reg_rdata <= receiver_filter_setup_q;
        `RLTS_ADDR_RX_GAIN: o_reg_rdata <= receiver_gain_mixer_setup_q;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver configuration fields
  // ----------------------------------------------------------------
  // The analog front end decodes these; mixer_trim pairing with the
  // supply lowering bit is left to the host software.
  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_filter_cfg <= '0;
      o_gain_cfg <= '0;
    end
    else
    begin
      o_filter_cfg.rx_filter_select <=
        receiver_filter_setup_q[`RLTS_FILT_SEL_LSB +: 2];
      o_filter_cfg.settle_fast <=
        receiver_filter_setup_q[`RLTS_FILT_SETTLE];
      o_filter_cfg.lf_open <=
        receiver_filter_setup_q[`RLTS_FILT_LF_OPEN];
      o_gain_cfg.gain_step <=
        receiver_gain_mixer_setup_q[`RLTS_GAIN_STEP_LSB +: 3];
      o_gain_cfg.hyst_step <=
        receiver_gain_mixer_setup_q[`RLTS_GAIN_HYST_LSB +: 2];
      o_gain_cfg.single_ended <=
        receiver_gain_mixer_setup_q[`RLTS_GAIN_MIX_BIT];
      o_gain_cfg.low_supply <=
        receiver_gain_mixer_setup_q[`RLTS_GAIN_LOWSUP_BIT];
      o_gain_cfg.attenuate <=
        receiver_gain_mixer_setup_q[`RLTS_GAIN_ATT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Fine timebase
  // ----------------------------------------------------------------
  // One tick every 6.4 us; the coarse timer divides this by four so
  // all three windows share one prescaler.
  localparam int PW = $clog2(STEP_CYCLES);
  logic [PW-1:0] presc_q;
  logic tick;

  assign tick = (presc_q == PW'(STEP_CYCLES - 1));

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_q <= '0;
    end
    else
    begin
      presc_q <= tick ? '0 : presc_q + PW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Interval timers
  // ----------------------------------------------------------------
  // A timer restarted mid-interval loses sub-step phase, so the first
  // step may be short by up to one tick period.
  logic txd_busy;
  logic txd_done;
  logic nr_busy;
  logic nr_done;
  logic blk_busy;
  logic lf_seen;

  rlts_wait_counter #(.WIDTH(8), .DIV(1)) u_tx_delay (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_tick(tick),
    .i_start(i_rx_end),
    .i_abort(!i_chip_enable),
    .i_value(tx_delay_wait_q),
    .o_busy(txd_busy),
    .o_done(txd_done)
  );

  rlts_wait_counter #(.WIDTH(8), .DIV(`RLTS_COARSE_PER_FINE)) u_no_reply (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_tick(tick),
    .i_start(i_tx_end),
    .i_abort((lf_seen && !i_tx_end) || !i_chip_enable),
    .i_value(no_reply_timeout_q),
    .o_busy(nr_busy),
    .o_done(nr_done)
  );

  rlts_wait_counter #(.WIDTH(8), .DIV(1)) u_rx_blank (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_tick(tick),
    .i_start(i_tx_end),
    .i_abort(!i_chip_enable),
    .i_value(receive_blanking_time_q),
    .o_busy(blk_busy),
    .o_done()
  );

  // ----------------------------------------------------------------
  // Link frequency detection
  // ----------------------------------------------------------------
  logic [3:0] lf_cnt_q;

  assign lf_seen = (lf_cnt_q >= 4'(LF_PERIODS_MIN));

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lf_cnt_q <= '0;
    end
    else if (i_tx_end)
    begin
      lf_cnt_q <= '0;
    end
    else if (i_lf_edge && !blk_busy && nr_busy && !lf_seen)
    begin
      lf_cnt_q <= lf_cnt_q + 4'(1);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_auto_tx_start <= 1'b0;
    end
    else
    begin
      o_auto_tx_start <= txd_done && i_auto_tx_pending;
    end
  end

  assign o_rx_enable = !blk_busy;
  assign o_rx_data_gated = i_rx_data && !blk_busy;

  // Set wins over a clear arriving in the same cycle.
  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_no_reply_irq <= 1'b0;
    end
    else if (nr_done)
    begin
      o_no_reply_irq <= 1'b1;
    end
    else if (i_irq_status_clear || !i_chip_enable)
    begin
      o_no_reply_irq <= 1'b0;
    end
  end

  assign o_irq_status = {7'h00, o_no_reply_irq};
endmodule // rlts_timing_rx_setup
`default_nettype wire

// File: rlts_timing_rx_setup_assertions.sv
`default_nettype none
module rlts_timing_rx_setup_chk
  import rlts_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_chip_enable,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic [7:0] o_reg_rdata,
  // Events and results
  input wire logic i_tx_end,
  input wire logic i_auto_tx_pending,
  input wire logic i_rx_data,
  input wire logic i_irq_status_clear,
  input wire logic o_auto_tx_start,
  input wire logic o_rx_enable,
  input wire logic o_rx_data_gated,
  input wire logic o_no_reply_irq,
  input wire logic [7:0] o_irq_status,
  input wire rlts_filt_t o_filter_cfg,
  input wire rlts_gain_t o_gain_cfg
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  property p_irq_map;
    o_irq_status == {7'h00, o_no_reply_irq};
  endproperty
  a_irq_map: assert property (p_irq_map)
    else $error("irq status map wrong");
  property p_gate;
    o_rx_data_gated == (i_rx_data & o_rx_enable);
  endproperty
  a_gate: assert property (p_gate)
    else $error("gated data wrong");
  property p_blank_cause;
    $fell(o_rx_enable) |-> $past(i_tx_end);
  endproperty
  a_blank_cause: assert property (p_blank_cause)
    else $error("receiver off without tx end");
  property p_start_pulse;
    o_auto_tx_start |=> !o_auto_tx_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("auto start too long");
  property p_start_pend;
    o_auto_tx_start |-> $past(i_auto_tx_pending);
  endproperty
  a_start_pend: assert property (p_start_pend)
    else $error("auto start without pending");
  property p_irq_hold;
    o_no_reply_irq && !i_irq_status_clear && i_chip_enable
      |=> o_no_reply_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped");
  property p_irq_late;
    i_tx_end && !o_no_reply_irq |=> !o_no_reply_irq [*3];
  endproperty
  a_irq_late: assert property (p_irq_late)
    else $error("irq too soon");
  property p_rdback;
    i_reg_write && i_chip_enable && i_reg_addr == 8'h07
      ##1 ($stable(i_reg_addr) && !i_reg_write && i_chip_enable)
      |=> o_reg_rdata == $past(i_reg_wdata, 2);
  endproperty
  a_rdback: assert property (p_rdback)
    else $error("readback wrong");
  property p_unmap;
    i_reg_addr == 8'h0B |=> o_reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_disable;
    !i_chip_enable [*3] |-> o_filter_cfg == 4'h1
      && o_gain_cfg == 8'h01 && !o_no_reply_irq;
  endproperty
  a_disable: assert property (p_disable)
    else $error("disable presets wrong");
  c_irq: cover property ($rose(o_no_reply_irq));
  c_start: cover property (o_auto_tx_start);
  c_blank: cover property ($fell(o_rx_enable));
endmodule // rlts_timing_rx_setup_chk
bind rlts_timing_rx_setup rlts_timing_rx_setup_chk chk_u (
  .i_clock, .i_rst_n, .i_chip_enable, .i_reg_addr, .i_reg_wdata,
  .i_reg_write, .o_reg_rdata, .i_tx_end, .i_auto_tx_pending,
  .i_rx_data, .i_irq_status_clear, .o_auto_tx_start, .o_rx_enable,
  .o_rx_data_gated, .o_no_reply_irq, .o_irq_status, .o_filter_cfg,
  .o_gain_cfg
);
`default_nettype wire

// File: rlts_wait_counter.sv
`default_nettype none
`include "rlts_cfg.svh"
module rlts_wait_counter
  import rlts_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DIV = 1
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Timebase and control
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [WIDTH-1:0] i_value,
  // Status
  output logic o_busy,
  output logic o_done
);
  localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;
  rlts_cnt_state_t state_q;
  logic [WIDTH-1:0] count_q;
  logic [DW-1:0] sub_q;
  logic last_sub;

  assign last_sub = (sub_q == DW'(DIV - 1));
  assign o_busy = (state_q == RLTS_RUN);

  // Load on start, count down one step per tick group.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= RLTS_IDLE;
      count_q <= '0;
      sub_q <= '0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_abort)
      begin
        state_q <= RLTS_IDLE;
      end
      else if (i_start)
      begin
        count_q <= i_value;
        sub_q <= '0;
        state_q <= (i_value == '0) ? RLTS_IDLE : RLTS_RUN;
      end
      else
      begin
        case (state_q)
          RLTS_RUN:
          begin
            if (i_tick)
            begin
              sub_q <= last_sub ? '0 : sub_q + DW'(1);
              if (last_sub)
              begin
                count_q <= count_q - WIDTH'(1);
                if (count_q == WIDTH'(1))
                begin
                  state_q <= RLTS_IDLE;
                  o_done <= 1'b1;
                end
              end
            end
          end
          default:
          begin
            state_q <= RLTS_IDLE;
          end
        endcase
      end
    end
  end
endmodule // rlts_wait_counter
`default_nettype wire

// File: tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rlts_pkg::*;
  localparam int STEP = 4;
  logic i_clock = 0, i_rst_n = 0, i_chip_enable = 1, reply = 0;
  logic [7:0] i_reg_addr = 0, i_reg_wdata = 0, o_reg_rdata;
  logic i_reg_write = 0, i_tx_end = 0, i_rx_end = 0;
  logic i_auto_tx_pending = 0, i_irq_status_clear = 0, i_lf_edge;
  logic i_rx_data, o_auto_tx_start, o_rx_enable, o_rx_data_gated;
  logic o_no_reply_irq;
  logic [7:0] o_irq_status;
  rlts_filt_t o_filter_cfg;
  rlts_gain_t o_gain_cfg;
  int num_errors = 0, check_count = 0;
  initial
  begin
    forever #20 i_clock = ~i_clock;
  end
  rlts_timing_rx_setup #(.STEP_CYCLES(STEP)) dut_u (.i_clock,
    .i_rst_n, .i_chip_enable, .i_reg_addr, .i_reg_wdata, .i_reg_write,
    .o_reg_rdata, .i_tx_end, .i_rx_end, .i_auto_tx_pending, .i_lf_edge,
    .i_rx_data, .i_irq_status_clear, .o_auto_tx_start, .o_rx_enable,
    .o_rx_data_gated, .o_no_reply_irq, .o_irq_status, .o_filter_cfg,
    .o_gain_cfg);
  rlts_tag_model tag_u (.i_clock, .i_tx_end, .i_reply(reply),
    .o_lf_edge(i_lf_edge), .o_rx_data(i_rx_data));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_rng(input string n, input int lo, hi, v);
    check_count++;
    if (v < lo || v > hi)
    begin
      num_errors++;
      $display("wrong value %s exp %0d..%0d got %0d", n, lo, hi, v);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge i_clock);
    {i_reg_addr, i_reg_wdata, i_reg_write} = {a, d, 1'b1};
    @(negedge i_clock);
    i_reg_write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge i_clock);
    i_reg_addr = a;
    repeat (2) @(negedge i_clock);
    chk8("rdata", e, o_reg_rdata);
  endtask
  task automatic pulse(input int w);
    @(negedge i_clock);
    {i_irq_status_clear, i_rx_end, i_tx_end} = 3'b001 << w;
    @(negedge i_clock);
    {i_irq_status_clear, i_rx_end, i_tx_end} = 3'b000;
  endtask
  function automatic logic sig(input int w);
    return w == 0 ? o_rx_enable : w == 1 ? o_no_reply_irq
      : o_auto_tx_start;
  endfunction
  // A wait that must end and does not ends the run at once.
  task automatic meas(input int w, lim, input bit must, output int n);
    n = 0;
    while (sig(w) !== 1'b1 && n < lim)
    begin
      @(negedge i_clock);
      n++;
    end
    if (must && n == lim)
    begin
      chk_rng("timeout", 0, lim - 1, n);
      summarize();
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] pre [5] = '{8'h00, 8'h07, 8'h07, 8'h41, 8'h01};
    for (int i = 0; i < 5; i++)
      rd(8'h06 + 8'(i), pre[i]);
    rd(8'h0B, 8'h00);
  endtask
  task automatic t_cfg;
    logic [7:0] v;
    for (int i = 0; i < 4; i++)
    begin
      v = 8'(i * 5);
      wr(8'h09, v);
      rd(8'h09, v);
      chk8("filter", v, {4'h0, o_filter_cfg});
    end
    wr(8'h0A, 8'hFC);
    rd(8'h0A, 8'hFC);
    chk8("gain", 8'hFC, o_gain_cfg);
    wr(8'h0A, 8'h03);
    rd(8'h0A, 8'h03);
    chk8("gain", 8'h03, o_gain_cfg);
  endtask
  task automatic t_blank;
    int n;
    int b [3] = '{0, 1, 3};
    foreach (b[i])
    begin
      wr(8'h08, 8'(b[i]));
      pulse(0);
      if (b[i] != 0)
        chk8("gated", 8'h00, 8'(o_rx_data_gated));
      meas(0, 40, 1, n);
      chk8("open", 8'(i_rx_data), 8'(o_rx_data_gated));
      if (b[i] == 0)
        chk_rng("blank", 0, 0, n);
      else
        chk_rng("blank", (b[i] - 1) * STEP, b[i] * STEP + 1, n);
    end
  endtask
  task automatic t_noreply;
    int n;
    wr(8'h08, 8'h01);
    wr(8'h07, 8'h01);
    pulse(0);
    repeat (10) @(negedge i_clock);
    pulse(0);
    meas(1, 100, 1, n);
    chk_rng("noreply", 3 * STEP, 4 * STEP + 2, n);
    chk8("status", 8'h01, o_irq_status);
    pulse(2);
    chk8("status", 8'h00, o_irq_status);
    wr(8'h07, 8'h00);
    pulse(0);
    meas(1, 100, 0, n);
    chk_rng("noreply off", 100, 100, n);
    wr(8'h07, 8'h02);
    reply = 1'b1;
    pulse(0);
    meas(1, 100, 0, n);
    chk_rng("replied", 100, 100, n);
    reply = 1'b0;
    pulse(0);
    meas(1, 100, 1, n);
    chk_rng("rearmed", 7 * STEP, 8 * STEP + 2, n);
    pulse(2);
  endtask
  task automatic t_delay;
    int n;
    i_auto_tx_pending = 1'b1;
    wr(8'h06, 8'h02);
    pulse(1);
    meas(2, 100, 1, n);
    chk_rng("delay", STEP, 2 * STEP + 3, n);
    wr(8'h06, 8'h00);
    pulse(1);
    meas(2, 60, 0, n);
    chk_rng("delay off", 60, 60, n);
    i_auto_tx_pending = 1'b0;
    wr(8'h06, 8'h01);
    pulse(1);
    meas(2, 60, 0, n);
    chk_rng("not pending", 60, 60, n);
  endtask
  task automatic t_disable;
    wr(8'h07, 8'h33);
    wr(8'h06, 8'h12);
    @(negedge i_clock);
    i_chip_enable = 1'b0;
    wr(8'h06, 8'h55);
    repeat (3) @(negedge i_clock);
    i_chip_enable = 1'b1;
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h07);
    rd(8'h09, 8'h41);
  endtask
  initial
  begin
    #(40 * 50000);
    chk_rng("watchdog", 0, 0, 1);
    summarize();
  end
  initial
  begin
    repeat (4) @(negedge i_clock);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clock);
    t_regs();
    t_cfg();
    t_blank();
    t_noreply();
    t_delay();
    t_disable();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
